// ===== common/usb_rx_irq_cfg.svh
`ifndef USB_RX_IRQ_CFG_SVH
`define USB_RX_IRQ_CFG_SVH

// register byte addresses
`define RX_IRQ_ENABLE_OFFSET 12'h008
`define RX_IRQ_STATUS_OFFSET 12'h00c

// enable register layout
`define RX_IRQ_WIDTH 16
`define RX_IRQ_RESERVED_BIT 0
`define RX_IRQ_ENABLE_RESET 16'hfffe
`define RX_IRQ_IMPL_MASK 16'hfffe

// status register reset
`define RX_IRQ_STATUS_RESET 16'h0000

// apb
`define RX_APB_ADDR_W 12
`define RX_APB_DATA_W 32
`define RX_APB_DATA_RESET 32'h0000_0000

`endif

// ===== common/usb_rx_irq_pkg.sv
`include "usb_rx_irq_cfg.svh"

package usb_rx_irq_pkg;

  typedef logic [`RX_IRQ_WIDTH-1:0] ep_vec_t;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b01,
    APB_ACCESS = 2'b10
  } apb_phase_t;

  typedef struct packed {
    apb_phase_t phase;
    logic [`RX_APB_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    ep_vec_t enable;
  } regs_state_t;

  typedef struct packed {
    ep_vec_t bits;
  } status_state_t;

  typedef struct packed {
    logic irq;
  } combine_state_t;

endpackage

// ===== logic/rx_status_bank.sv
`timescale 1ns/100ps
`include "usb_rx_irq_cfg.svh"

module rx_status_bank
  import usb_rx_irq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events and clears
  input wire ep_vec_t set_ep,
  input wire ep_vec_t clear_ep,
  // sticky flags
  output ep_vec_t status
);

  status_state_t state;
  status_state_t next_state;

  // set beats a clear in the same cycle
  always_comb begin
    next_state = state;
    next_state.bits = ((state.bits & ~clear_ep) | set_ep) & `RX_IRQ_IMPL_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.bits <= `RX_IRQ_STATUS_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign status = state.bits;

endmodule // rx_status_bank

// ===== logic/irq_combiner.sv
`timescale 1ns/100ps

module irq_combiner
  import usb_rx_irq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sources
  input wire ep_vec_t status,
  input wire ep_vec_t enable,
  input wire logic other_irq,
  // level interrupt
  output logic irq
);

  combine_state_t state;
  combine_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.irq = (|(status & enable)) | other_irq;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign irq = state.irq;

endmodule // irq_combiner

// ===== logic/usb_rx_endpoint_irq_mask.sv
`timescale 1ns/100ps
`include "usb_rx_irq_cfg.svh"

module usb_rx_endpoint_irq_mask
  import usb_rx_irq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RX_APB_ADDR_W-1:0] paddr,
  input wire logic [`RX_APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [`RX_APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive endpoint events, one-cycle pulses
  input wire ep_vec_t rx_event,
  // other usb interrupt sources, level
  input wire logic other_irq,
  // interrupt to the system
  output logic usb_irq
);

  regs_state_t state;
  regs_state_t next_state;
  ep_vec_t rx_status;
  ep_vec_t clear_ep;
  logic wr_take;

  // byte enables to a 16-bit lane mask
  function automatic ep_vec_t lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic hit(
    input logic [`RX_APB_ADDR_W-1:0] addr,
    input logic [`RX_APB_ADDR_W-1:0] offset
  );
    hit = (addr == offset);
  endfunction

  function automatic logic mapped(input logic [`RX_APB_ADDR_W-1:0] addr);
    mapped = hit(addr, `RX_IRQ_ENABLE_OFFSET) | hit(addr, `RX_IRQ_STATUS_OFFSET);
  endfunction

  // write takes effect at the access edge
  assign wr_take = (state.phase == APB_ACCESS) && psel && penable && pwrite;

  // write-one-to-clear on the status register
  always_comb begin
    clear_ep = '0;
    if (wr_take && hit(paddr, `RX_IRQ_STATUS_OFFSET)) begin
      clear_ep = pwdata[`RX_IRQ_WIDTH-1:0] & lane_mask(pstrb) & `RX_IRQ_IMPL_MASK;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state.phase)
      APB_IDLE: begin
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;
        if (psel && !penable) begin
          next_state.phase = APB_ACCESS;
          next_state.pready = 1'b1;
          next_state.pslverr = !mapped(paddr);
          next_state.prdata = `RX_APB_DATA_RESET;
          if (!pwrite && hit(paddr, `RX_IRQ_ENABLE_OFFSET)) begin
            // reserved bit reads zero
            next_state.prdata[`RX_IRQ_WIDTH-1:0] = state.enable & `RX_IRQ_IMPL_MASK;
          end else if (!pwrite && hit(paddr, `RX_IRQ_STATUS_OFFSET)) begin
            next_state.prdata[`RX_IRQ_WIDTH-1:0] = rx_status;
          end
        end
      end
      APB_ACCESS: begin
        next_state.phase = APB_IDLE;
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;
        if (wr_take && hit(paddr, `RX_IRQ_ENABLE_OFFSET)) begin
          // byte lanes merge, bit 0 stays zero
          next_state.enable = ((state.enable & ~lane_mask(pstrb))
                              | (pwdata[`RX_IRQ_WIDTH-1:0] & lane_mask(pstrb)))
                              & `RX_IRQ_IMPL_MASK;
        end
      end
      default: begin
        next_state.phase = APB_IDLE;
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.phase <= APB_IDLE;
      state.prdata <= `RX_APB_DATA_RESET;
      state.pready <= 1'b0;
      state.pslverr <= 1'b0;
      state.enable <= `RX_IRQ_ENABLE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;

  // event sets status regardless of the enable
  rx_status_bank u_status (
    .pclk(pclk),
    .presetn(presetn),
    .set_ep(rx_event & `RX_IRQ_IMPL_MASK),
    .clear_ep(clear_ep),
    .status(rx_status)
  );

  // enabled status ORed with other sources, registered
  irq_combiner u_combine (
    .pclk(pclk),
    .presetn(presetn),
    .status(rx_status),
    .enable(state.enable),
    .other_irq(other_irq),
    .irq(usb_irq)
  );

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic enable_written;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_written <= 1'b0;
    end else if (wr_take && hit(paddr, `RX_IRQ_ENABLE_OFFSET)) begin
      enable_written <= 1'b1;
    end
  end

  sequence s_enable_write;
    psel && penable && pready && pwrite && (paddr == `RX_IRQ_ENABLE_OFFSET) && (pstrb[1:0] == 2'b11);
  endsequence

  sequence s_enable_read_setup;
    psel && !penable && !pwrite && (paddr == `RX_IRQ_ENABLE_OFFSET);
  endsequence

  sequence s_masked_event(int n);
    rx_event[n] && !state.enable[n];
  endsequence

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_enable_access;
    psel && penable && pready && pwrite && (paddr == `RX_IRQ_ENABLE_OFFSET);
  endsequence

  sequence s_status_write;
    psel && penable && pready && pwrite && (paddr == `RX_IRQ_STATUS_OFFSET) && (pstrb[1:0] == 2'b11);
  endsequence

  sequence s_status_read_setup;
    psel && !penable && !pwrite && (paddr == `RX_IRQ_STATUS_OFFSET);
  endsequence

  a_width_update: assert property (
    s_enable_write |=> (state.enable == ($past(pwdata[15:0]) & 16'hfffe)))
    else $error("enable register did not take written value");

  a_endpoint_map: assert property (
    (rx_status[15] && state.enable[15] && !(|(rx_status[14:0] & state.enable[14:0])) && !other_irq)
      |=> usb_irq)
    else $error("endpoint 15 enable does not govern endpoint 15");

  a_enabled_raise: assert property (
    (|(rx_status & state.enable)) |=> usb_irq)
    else $error("enabled status did not raise interrupt");

  a_masked_sets: assert property (
    s_masked_event(5) |=> rx_status[5])
    else $error("masked event did not set status");

  a_masked_quiet: assert property (
    (!(|(rx_status & state.enable)) && !other_irq) |=> !usb_irq)
    else $error("interrupt raised with all sources masked");

  a_reset_value: assert property (
    !enable_written |-> (state.enable == 16'hfffe))
    else $error("enable register left reset value without a write");

  a_reserved_zero: assert property (
    s_enable_read_setup ##1 (psel && penable && pready) |-> (prdata[0] == 1'b0) && (prdata[31:16] == 16'h0000))
    else $error("reserved bit or upper bits read nonzero");

  a_late_enable: assert property (
    ($rose(|(rx_status & state.enable)) || $rose(other_irq)) |=> usb_irq)
    else $error("interrupt not asserted after source rose");

  a_one_wait: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not in one cycle");

  a_enable_hold: assert property (
    !(psel && penable && pready && pwrite && (paddr == `RX_IRQ_ENABLE_OFFSET))
      |=> $stable(state.enable))
    else $error("enable register changed without a write");

  a_lane_keep: assert property (
    s_enable_access |=> (((state.enable ^ $past(state.enable)) & ~$past(lane_mask(pstrb))) == 16'h0000))
    else $error("enable lane changed with its strobe low");

  a_enable_read: assert property (
    s_enable_read_setup |=> (prdata[15:0] == $past(state.enable)))
    else $error("enable read data differs from register");

  a_status_read: assert property (
    s_status_read_setup |=> (prdata[15:0] == $past(rx_status)))
    else $error("status read data differs from flags");

  a_status_sticky: assert property (
    !(psel && penable && pready && pwrite && (paddr == `RX_IRQ_STATUS_OFFSET))
      |=> ((rx_status & $past(rx_status)) == $past(rx_status)))
    else $error("status flag dropped without a clear");

  a_event_sets: assert property (
    (|(rx_event & `RX_IRQ_IMPL_MASK))
      |=> ((rx_status & $past(rx_event & `RX_IRQ_IMPL_MASK)) == $past(rx_event & `RX_IRQ_IMPL_MASK)))
    else $error("event did not set its status flag");

  a_clear_applies: assert property (
    s_status_write |=> ((rx_status & $past(pwdata[15:0]) & ~$past(rx_event)) == 16'h0000))
    else $error("status flag survived a clear");

  a_enabled_event: assert property (
    ((|(rx_event & state.enable)) && !(psel && penable && pready && pwrite && (paddr == `RX_IRQ_ENABLE_OFFSET)))
      |-> ##2 usb_irq)
    else $error("enabled event did not raise interrupt");

  a_enable_at_once: assert property (
    s_enable_write ##0 (|(rx_status & pwdata[15:0])) |-> ##2 usb_irq)
    else $error("enabling a set flag did not raise interrupt");

  a_other_raise: assert property (
    other_irq |=> usb_irq)
    else $error("other source did not raise interrupt");

  a_masked_stays: assert property (
    s_masked_event(9) ##1 (!(|(rx_status & state.enable)) && !other_irq) |=> !usb_irq)
    else $error("masked event raised interrupt");

  a_rise_cause: assert property (
    $rose(usb_irq) |-> $past((|(rx_status & state.enable)) || other_irq))
    else $error("interrupt rose with no source");

  a_fall_cause: assert property (
    $fell(usb_irq) |-> $past(!(|(rx_status & state.enable)) && !other_irq))
    else $error("interrupt fell with a source active");

  a_unmapped_err: assert property (
    s_setup ##0 !mapped(paddr) |=> (pready && pslverr))
    else $error("unmapped address gave no error");

  a_mapped_ok: assert property (
    s_setup ##0 mapped(paddr) |=> (pready && !pslverr))
    else $error("mapped address gave an error");

  a_unmapped_zero: assert property (
    s_setup ##0 !mapped(paddr) |=> (prdata == 32'h0000_0000))
    else $error("unmapped read returned data");

  a_write_data_zero: assert property (
    s_setup ##0 pwrite |=> (prdata == 32'h0000_0000))
    else $error("write access returned data");

  a_upper_zero: assert property (
    s_setup ##0 !pwrite |=> (prdata[31:16] == 16'h0000))
    else $error("upper read bits nonzero");

  a_err_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");

  a_ready_origin: assert property (
    pready |-> $past(psel && !penable))
    else $error("ready without a setup cycle");

endmodule // usb_rx_endpoint_irq_mask

// ===== verif/irq_ctrl_model.sv
`timescale 1ns/100ps

module irq_ctrl_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level line from the block
  input wire logic usb_irq,
  // interrupt entries taken
  output logic [7:0] taken
);
  logic seen;

  // one entry per new assertion of the level line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 1'b0;
      taken <= 8'h00;
    end else begin
      seen <= usb_irq;
      if (usb_irq && !seen) begin
        taken <= taken + 8'h01;
      end
    end
  end
endmodule // irq_ctrl_model

// ===== verif/usb_rx_endpoint_irq_mask_tb.sv
`timescale 1ns/100ps
`include "usb_rx_irq_cfg.svh"

module usb_rx_endpoint_irq_mask_tb;
  import usb_rx_irq_pkg::*;
  localparam logic [11:0] EN = `RX_IRQ_ENABLE_OFFSET;
  localparam logic [11:0] ST = `RX_IRQ_STATUS_OFFSET;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ep_vec_t rx_event = 16'h0000;
  logic other_irq = 1'b0;
  logic usb_irq;
  logic [7:0] taken;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int total_checks = 0;

  always #4 pclk = ~pclk;

  usb_rx_endpoint_irq_mask dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_event(rx_event), .other_irq(other_irq), .usb_irq(usb_irq));

  irq_ctrl_model icm_u (.pclk(pclk), .presetn(presetn), .usb_irq(usb_irq), .taken(taken));

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // setup then access, held until pready is seen at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task pulse(input ep_vec_t v);
    @(posedge pclk);
    rx_event <= v;
    @(posedge pclk);
    rx_event <= 16'h0000;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, EN, 32'h0);
    chk("enable after reset", rd, 32'h0000_fffe);
    chk("mapped no error", {31'h0, err}, 32'h0);
    settle(0);
    chk("irq after reset", {31'h0, usb_irq}, 32'h0);
    xfer(1'b1, EN, 32'h0000_ffff);
    xfer(1'b0, EN, 32'h0);
    chk("reserved bit", rd, 32'h0000_fffe);
    pstrb <= 4'h1;
    xfer(1'b1, EN, 32'h0000_0000);
    pstrb <= 4'hf;
    xfer(1'b0, EN, 32'h0);
    chk("lane kept", rd, 32'h0000_ff00);
    $display("test reset and reserved done");
    xfer(1'b1, EN, 32'h0);
    pulse(16'hffff);
    settle(2);
    chk("irq all masked", {31'h0, usb_irq}, 32'h0);
    xfer(1'b0, ST, 32'h0);
    chk("status while masked", rd, 32'h0000_fffe);
    for (int n = 1; n < 16; n++) begin
      xfer(1'b1, EN, 32'h1 << n);
      settle(2);
      chk("irq one enabled", {31'h0, usb_irq}, 32'h1);
      xfer(1'b1, ST, 32'h1 << n);
      settle(2);
      chk("irq others masked", {31'h0, usb_irq}, 32'h0);
    end
    $display("test per endpoint done");
    xfer(1'b0, EN, 32'h0);
    xfer(1'b1, EN, rd | 32'h0000_0020);
    pulse(16'h0020);
    settle(2);
    chk("irq on event", {31'h0, usb_irq}, 32'h1);
    chk("entries taken", {24'h0, taken}, 32'h10);
    xfer(1'b1, ST, 32'h0000_0020);
    xfer(1'b1, EN, 32'h0);
    other_irq <= 1'b1;
    settle(2);
    chk("irq other source", {31'h0, usb_irq}, 32'h1);
    @(posedge pclk);
    other_irq <= 1'b0;
    xfer(1'b0, 12'h010, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test combine and unmapped done");
    pulse(16'h0030);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, EN, 32'h0);
    chk("enable after second reset", rd, 32'h0000_fffe);
    xfer(1'b0, ST, 32'h0);
    chk("status after second reset", rd, 32'h0);
    $display("test second reset done");
    final_report();
  end
endmodule // usb_rx_endpoint_irq_mask_tb
